// ---- timer_pkg.sv ----
// constants and types shared by the timer subsystem
package timer_pkg;

  localparam int CHN_NUM = 6;
  localparam int CHN_W   = 16;
  localparam int CHAIN_W = CHN_NUM * CHN_W;
  localparam int STB_W   = 32;
  localparam int RTC_W   = 32;
  localparam int CALIB_W = 16;
  localparam int SEL_W   = 3;
  localparam int PWM_CHN = 0;

  // standby clock nominal rate, Hz
  localparam int STBY_CLK_HZ = 32768;

  localparam logic [CHN_W-1:0]   CHN_COUNT_RST = 16'h0000;
  localparam logic [CHN_W-1:0]   CHN_PERIOD_MAX = 16'hffff;
  localparam logic [STB_W-1:0]   STB_COUNT_RST = 32'h0000_0000;
  localparam logic [RTC_W-1:0]   RTC_COUNT_RST = 32'h0000_0000;
  localparam logic [CALIB_W-1:0] RTC_PRE_RST   = 16'h0000;
  // standby ticks per second minus one, used until a calibration loads
  localparam logic [CALIB_W-1:0] RTC_DIV_TOP_RST =
    CALIB_W'(STBY_CLK_HZ - 1);

  typedef enum logic [2:0] {
    CH_STOPPED = 3'b001,
    CH_PRIMING = 3'b010,
    CH_RUNNING = 3'b100
  } chan_state_e;

endpackage

// ---- standby_timer.sv ----
// 32-bit standby timer with wake-up event and exit capture
`timescale 1ns/100ps
module standby_timer (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        stby_tick,
  input  wire logic                        start,
  input  wire logic                        stop,
  input  wire logic [timer_pkg::STB_W-1:0] period,
  input  wire logic                        ps_exit,
  output logic      [timer_pkg::STB_W-1:0] count,
  output logic      [timer_pkg::STB_W-1:0] capture,
  output logic                             wake,
  output logic                             running
);

  logic                        next_running;
  logic [timer_pkg::STB_W-1:0] next_count;
  logic [timer_pkg::STB_W-1:0] next_capture;
  logic                        next_wake;

  always_comb begin
    next_running = running;
    next_count   = count;
    next_capture = capture;
    next_wake    = 1'b0;
    if (stop) begin // RULE16
      next_running = 1'b0;
    end else if (start) begin // RULE16
      next_running = 1'b1;
      next_count   = timer_pkg::STB_COUNT_RST;
    end else if (running && stby_tick) begin // RULE14
      if (count == period) begin // RULE15
        next_count = timer_pkg::STB_COUNT_RST;
        next_wake  = 1'b1;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
    // capture the live count, so the elapsed sleep is visible later
    if (ps_exit) begin // RULE17
      next_capture = count;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      count   <= timer_pkg::STB_COUNT_RST;
      capture <= timer_pkg::STB_COUNT_RST;
      wake    <= 1'b0;
    end else begin
      running <= next_running;
      count   <= next_count;
      capture <= next_capture;
      wake    <= next_wake;
    end
  end

endmodule

// ---- rtc_counter.sv ----
// calibrated seconds counter on the standby tick
`timescale 1ns/100ps
module rtc_counter (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          stby_tick,
  input  wire logic                          enable,
  input  wire logic                          calib_load,
  input  wire logic [timer_pkg::CALIB_W-1:0] calib_value,
  output logic      [timer_pkg::RTC_W-1:0]   seconds
);

  logic [timer_pkg::CALIB_W-1:0] div_top;
  logic [timer_pkg::CALIB_W-1:0] next_div_top;
  logic [timer_pkg::CALIB_W-1:0] pre;
  logic [timer_pkg::CALIB_W-1:0] next_pre;
  logic [timer_pkg::RTC_W-1:0]   next_seconds;

  always_comb begin
    next_div_top = div_top;
    next_pre     = pre;
    next_seconds = seconds;
    if (calib_load) begin // RULE19
      next_div_top = calib_value;
    end
    if (!enable) begin // RULE20
      next_pre     = timer_pkg::RTC_PRE_RST;
      next_seconds = timer_pkg::RTC_COUNT_RST;
    end else if (stby_tick) begin // RULE13
      if (pre >= div_top) begin // RULE18
        next_pre     = timer_pkg::RTC_PRE_RST;
        next_seconds = seconds + 32'h0000_0001;
      end else begin
        next_pre = pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_top <= timer_pkg::RTC_DIV_TOP_RST;
      pre     <= timer_pkg::RTC_PRE_RST;
      seconds <= timer_pkg::RTC_COUNT_RST;
    end else begin
      div_top <= next_div_top;
      pre     <= next_pre;
      seconds <= next_seconds;
    end
  end

endmodule

// ---- timer_unit.sv ----
// timer subsystem top: six cascadable channels, pwm, standby timer, rtc
//
// Notes on behaviour
// RULE1 - six 16-bit channels, own period, start, stop
// RULE2 - channels count on the cpu clock
// RULE3 - configure period, then start or stop on command
// RULE4 - upper is channel n, lower is n-1
// RULE5 - cascaded upper steps on lower period match
// RULE6 - all six may chain into 96 bits
// RULE7 - independent periods; ffff lower gives 32 bits
// RULE8 - read upper alone or pair combined
// RULE9 - pair cascades only after one lower period
// RULE10 - only channel 0 has pwm logic
// RULE11 - pwm period and high-time are 16-bit ticks
// RULE12 - pwm exported for a pin multiplexer
// RULE13 - standby timer and rtc use standby clock
// RULE14 - standby timer is 32 bits at 32768 Hz
// RULE15 - standby timer runs asleep, wakes at period
// RULE16 - standby timer start, stop and period
// RULE17 - count captured on every power-save exit
// RULE18 - rtc is 32 bits, one per second
// RULE19 - rtc takes a rate calibration value
// RULE20 - rtc disable clears count to zero
// RULE21 - rtc seconds readable at any time
// RULE22 - pwm high below high-time, low after
// RULE23 - period match event, count restarts at zero
//
// limits worth knowing:
// - cascade carries ripple through up to six channels in one cycle, so a
//   full chain sets the longest combinational path of the block
// - a period of n gives n+1 states; ffff on the lower channel of a pair
//   makes the pair one 32-bit counter
// - pair readouts lag the live counts by one edge, and both halves come
//   from the same sample
// - start is ignored while a channel runs or primes; stop always wins
// - a cascaded upper channel discards the first lower match after start,
//   so host readings are only valid once chn_cascade_ok is high
// - chn_running and chn_cascade_ok trail the channel state by one edge
// - pwm_out is low from one edge after channel 0 stops or pwm is disabled
// - stb_capture takes the live count on every ps_exit, whatever woke
//   the device, so firmware can tell how long it slept
// - disabling the rtc clears seconds and prescaler; the calibration
//   value survives until the next load

`timescale 1ns/100ps
module timer_unit (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,

  // system timer channels, channel i in bits of slice i
  input  wire logic [timer_pkg::CHAIN_W-1:0] chn_period,
  input  wire logic [timer_pkg::CHN_NUM-1:0] chn_start,
  input  wire logic [timer_pkg::CHN_NUM-1:0] chn_stop,
  input  wire logic [timer_pkg::CHN_NUM-1:0] chn_cascade,
  output logic      [timer_pkg::CHAIN_W-1:0] chn_count,
  output logic      [timer_pkg::CHN_NUM-1:0] chn_match,
  output logic      [timer_pkg::CHN_NUM-1:0] chn_running,
  output logic      [timer_pkg::CHN_NUM-1:0] chn_cascade_ok,

  // cascaded pair readout
  input  wire logic [timer_pkg::SEL_W-1:0]   pair_sel,
  output logic      [timer_pkg::CHN_W-1:0]   pair_upper,
  output logic      [2*timer_pkg::CHN_W-1:0] pair_combined,

  // pwm on channel 0
  input  wire logic                          pwm_enable,
  input  wire logic [timer_pkg::CHN_W-1:0]   pwm_high_time,
  output logic                               pwm_out,

  // standby domain
  input  wire logic                          stby_tick,
  input  wire logic                          stb_start,
  input  wire logic                          stb_stop,
  input  wire logic [timer_pkg::STB_W-1:0]   stb_period,
  input  wire logic                          ps_exit,
  output logic      [timer_pkg::STB_W-1:0]   stb_count,
  output logic      [timer_pkg::STB_W-1:0]   stb_capture,
  output logic                               stb_wake,
  output logic                               stb_running,
  input  wire logic                          rtc_enable,
  input  wire logic                          rtc_calib_load,
  input  wire logic [timer_pkg::CALIB_W-1:0] rtc_calib_value,
  output logic      [timer_pkg::RTC_W-1:0]   rtc_seconds
);

  ////////////////////////////////////////////////////////////////////////
  // channel array

  // carry[i] is the period match of channel i-1; carry[0] never fires
  logic                        carry    [timer_pkg::CHN_NUM+1];
  logic [timer_pkg::CHN_W-1:0] cnt_all  [timer_pkg::CHN_NUM];
  logic                        run_all  [timer_pkg::CHN_NUM];
  logic                        casc_all [timer_pkg::CHN_NUM];
  logic [timer_pkg::CHN_NUM-1:0] next_match;

  assign carry[0] = 1'b0;
  // carry[6] is the match of channel 5 and only feeds chn_match

  // one counter per channel; cascade and pwm hang off the slices

  genvar gi;
  generate
    for (gi = 0; gi < timer_pkg::CHN_NUM; gi = gi + 1) begin : gen_chn
      logic [timer_pkg::CHN_W-1:0] cnt_q;
      logic [timer_pkg::CHN_W-1:0] next_cnt;
      logic [timer_pkg::CHN_W-1:0] period;
      timer_pkg::chan_state_e      st_q;
      timer_pkg::chan_state_e      next_st;
      logic                        casc;
      logic                        step;
      logic                        hit;
      logic                        is_running;

      assign period = chn_period[gi*timer_pkg::CHN_W +: timer_pkg::CHN_W];
      // channel 0 has no lower neighbour, so it never cascades
      assign casc = (gi != 0) && chn_cascade[gi]; // RULE4

      always_comb begin
        next_st  = st_q;
        next_cnt = cnt_q;
        step     = 1'b0;
        case (st_q)
          timer_pkg::CH_STOPPED: begin
            // count holds here until the next start
            if (chn_start[gi]) begin // RULE3
              next_cnt = timer_pkg::CHN_COUNT_RST;
              if (casc) begin
                next_st = timer_pkg::CH_PRIMING;
              end else begin
                next_st = timer_pkg::CH_RUNNING;
              end
            end
          end
          timer_pkg::CH_PRIMING: begin
            // first lower match only arms the link
            if (carry[gi]) begin // RULE9
              next_st = timer_pkg::CH_RUNNING;
            end
          end
          timer_pkg::CH_RUNNING: begin
            // a plain channel steps on every sys_clk edge
            if (casc) begin
              step = carry[gi]; // RULE5
            end else begin
              step = 1'b1; // RULE2
            end
            if (step) begin
              if (cnt_q == period) begin // RULE23
                next_cnt = timer_pkg::CHN_COUNT_RST;
              end else begin
                next_cnt = cnt_q + 16'h0001; // RULE1
              end
            end
          end
          default: begin
            // any other code parks the channel stopped
            next_st = timer_pkg::CH_STOPPED;
          end
        endcase
        // stop wins over start and running for the state; the count still takes this cycle's step or clear
        if (chn_stop[gi]) begin // RULE3
          next_st = timer_pkg::CH_STOPPED;
        end
      end

      // match feeds the next channel in the same cycle, so a chain of
      // six ripples combinationally through all carries
      assign hit          = step && (cnt_q == period); // RULE6 RULE7
      assign carry[gi+1]  = hit;
      assign cnt_all[gi]  = cnt_q;
      assign is_running   = (st_q == timer_pkg::CH_RUNNING);
      assign run_all[gi]  = is_running;
      assign casc_all[gi] = casc && is_running;
      assign chn_count[gi*timer_pkg::CHN_W +: timer_pkg::CHN_W] = cnt_q;

      // state and count register together, so a stop freezes the count
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          st_q  <= timer_pkg::CH_STOPPED;
          cnt_q <= timer_pkg::CHN_COUNT_RST;
        end else begin
          st_q  <= next_st;
          cnt_q <= next_cnt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status flags

  logic [timer_pkg::CHN_NUM-1:0] next_running;
  logic [timer_pkg::CHN_NUM-1:0] next_cascade_ok;
  // chn_match doubles as the interrupt request of each channel

  always_comb begin
    for (int k = 0; k < timer_pkg::CHN_NUM; k++) begin
      next_match[k]      = carry[k+1]; // RULE23
      next_running[k]    = run_all[k];
      next_cascade_ok[k] = casc_all[k];
    end
  end

  // flags trail the channel state by one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chn_match      <= '0;
      chn_running    <= '0;
      chn_cascade_ok <= '0;
    end else begin
      chn_match      <= next_match;
      chn_running    <= next_running;
      chn_cascade_ok <= next_cascade_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pair readout

  logic [timer_pkg::CHN_W-1:0]   next_upper;
  logic [2*timer_pkg::CHN_W-1:0] next_combined;

  always_comb begin
    next_upper    = timer_pkg::CHN_COUNT_RST;
    next_combined = {timer_pkg::CHN_COUNT_RST, timer_pkg::CHN_COUNT_RST};
    // a select of 0 or above the last channel names no pair: read zero
    // both halves come from one sample, so no torn reads between them
    for (int k = 1; k < timer_pkg::CHN_NUM; k++) begin
      if (pair_sel == k[timer_pkg::SEL_W-1:0]) begin // RULE8
        next_upper    = cnt_all[k];
        next_combined = {cnt_all[k], cnt_all[k-1]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pair_upper    <= timer_pkg::CHN_COUNT_RST;
      pair_combined <= {timer_pkg::CHN_COUNT_RST, timer_pkg::CHN_COUNT_RST};
    end else begin
      pair_upper    <= next_upper;
      pair_combined <= next_combined;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm, channel 0 only

  logic next_pwm;
  logic pwm_active;
  logic pwm_below;

  // period is the channel 0 period; a high-time above it keeps the
  // output high for the whole cycle
  assign pwm_active = pwm_enable && run_all[timer_pkg::PWM_CHN]; // RULE10
  // compare with the live count, so the pin trails the count by one edge
  assign pwm_below  = (cnt_all[timer_pkg::PWM_CHN] < pwm_high_time); // RULE11

  always_comb begin
    next_pwm = pwm_active && pwm_below; // RULE22
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_pwm; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // standby domain

  // stby_tick marks each standby clock period as a one-cycle enable, so
  // the always-on parts share sys_clk without a second clock domain
  standby_timer u_standby (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .stby_tick (stby_tick),
    .start     (stb_start),
    .stop      (stb_stop),
    .period    (stb_period),
    .ps_exit   (ps_exit),
    .count     (stb_count),
    .capture   (stb_capture),
    .wake      (stb_wake),
    .running   (stb_running)
  );

  // the rtc divider runs from the same tick; a calibration load retimes
  // every later second
  rtc_counter u_rtc (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .stby_tick   (stby_tick),
    .enable      (rtc_enable),
    .calib_load  (rtc_calib_load),
    .calib_value (rtc_calib_value),
    .seconds     (rtc_seconds) // RULE21
  );

endmodule

// ---- timer_unit_chk.sv ----
// port-level assertions for the timer subsystem
`timescale 1ns/100ps
module timer_unit_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [95:0] chn_period,
  input wire logic [5:0]  chn_start,
  input wire logic [5:0]  chn_stop,
  input wire logic [5:0]  chn_cascade,
  input wire logic [95:0] chn_count,
  input wire logic [5:0]  chn_match,
  input wire logic [5:0]  chn_running,
  input wire logic [5:0]  chn_cascade_ok,
  input wire logic [2:0]  pair_sel,
  input wire logic [15:0] pair_upper,
  input wire logic [31:0] pair_combined,
  input wire logic        pwm_enable,
  input wire logic [15:0] pwm_high_time,
  input wire logic        pwm_out,
  input wire logic        stby_tick,
  input wire logic        stb_start,
  input wire logic        stb_stop,
  input wire logic [31:0] stb_period,
  input wire logic        ps_exit,
  input wire logic [31:0] stb_count,
  input wire logic [31:0] stb_capture,
  input wire logic        stb_wake,
  input wire logic        stb_running,
  input wire logic        rtc_enable,
  input wire logic [31:0] rtc_seconds
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_go2;
    chn_start[2] && !chn_stop[2] && !chn_cascade[2] ##1 !chn_stop[2];
  endsequence
  // flag lags state, so a stop one edge back still shows running
  sequence s_run3;
    chn_running[3] && !chn_cascade[3] && !chn_stop[3] && !$past(chn_stop[3]);
  endsequence
  sequence s_tick;
    stb_running && stby_tick && !stb_start && !stb_stop && !$past(stb_stop);
  endsequence
  property p_start;
    s_go2 |-> ##1 chn_running[2];
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    chn_stop[2] |-> ##2 !chn_running[2];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_step;
    s_run3 ##0 chn_count[63:48] < chn_period[63:48]
    |=> chn_count[63:48] == $past(chn_count[63:48]) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");
  property p_wrap;
    s_run3 ##0 chn_count[63:48] == chn_period[63:48]
    |=> chn_count[63:48] == 16'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");
  property p_match;
    chn_match[3] && chn_period[63:48] != 16'h0 |=> !chn_match[3];
  endproperty
  a_match: assert property (p_match) else $error("match too long");
  // an unarmed upper half may not leave zero until the arm is flagged
  property p_arm;
    chn_cascade[1] && $past(chn_cascade[1]) && !chn_cascade_ok[1]
    && chn_count[31:16] == 16'h0
    |=> chn_count[31:16] == 16'h0 || chn_cascade_ok[1];
  endproperty
  a_arm: assert property (p_arm) else $error("upper moved unarmed");
  property p_pwm;
    chn_running[0] && $past(chn_running[0])
    |-> pwm_out == $past(pwm_enable && chn_count[15:0] < pwm_high_time);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong");
  property p_pair;
    pair_sel == 3'h1 |=> pair_combined == $past(chn_count[31:0])
    && pair_upper == $past(chn_count[31:16]);
  endproperty
  a_pair: assert property (p_pair) else $error("pair readout wrong");
  property p_stb_step;
    s_tick ##0 stb_count < stb_period |=> stb_count == $past(stb_count) + 32'h1;
  endproperty
  a_stb_step: assert property (p_stb_step) else $error("stb step");
  property p_wake;
    s_tick ##0 stb_count == stb_period |=> stb_wake && stb_count == 32'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_cap;
    ps_exit |=> stb_capture == $past(stb_count);
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  property p_rtc_off;
    !rtc_enable |=> rtc_seconds == 32'h0;
  endproperty
  a_rtc_off: assert property (p_rtc_off) else $error("rtc not clear");
endmodule

// ---- tb_top.sv ----
// self-checking bench for the timer subsystem
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  logic        sys_clk = '0;
  logic        rst = 1'h1;
  logic [95:0] chn_period = '0, chn_count;
  logic [5:0]  chn_start = '0, chn_stop = '0, chn_cascade = '0;
  logic [5:0]  chn_match, chn_running, chn_cascade_ok;
  logic [2:0]  pair_sel = 3'h1;
  logic [15:0] pair_upper, pwm_high_time = '0, rtc_calib_value = '0;
  logic [31:0] pair_combined, stb_period = '0, stb_count, stb_capture;
  logic [31:0] rtc_seconds, p;
  logic        pwm_enable = '0, pwm_out, stby_tick = '0, ps_exit = '0;
  logic        stb_start = '0, stb_stop = '0, stb_wake, stb_running;
  logic        rtc_enable = '0, rtc_calib_load = '0;
  logic [15:0] lf = 16'hd5ff, hi, per [6];
  int          n_fail = 0, total_checks = 0, cyc = 0, wakes = 0, g, i;
  timer_unit u_dut (.*);
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // standby ticks spaced four cycles, entered at a rising edge
  task automatic stick(input int n);
    repeat (n) begin
      stby_tick <= 1'h1;
      @(posedge sys_clk);
      stby_tick <= 1'h0;
      clk(3);
    end
  endtask
  // cycles between two match pulses of channel k
  task automatic gap(input int k, output int n);
    n = 0;
    do @(negedge sys_clk); while (chn_match[k] !== 1'h1 && ++n < 200);
    n = 0;
    do begin @(negedge sys_clk); n++; end
    while (chn_match[k] !== 1'h1 && n < 200);
  endtask
  // count the wake pulse half a cycle after it is launched
  always @(negedge sys_clk) begin
    if (stb_wake === 1'h1) wakes++;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk(12);
    @(negedge sys_clk);
    `CHK("reset count", 96'h0, chn_count)
    `CHK("reset rtc", 32'h0, rtc_seconds)
    @(posedge sys_clk);
    rst <= 1'h0;
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      per[k] = 16'h2 + {13'h0, lf[2:0]};
      chn_period[16*k +: 16] <= per[k];
    end
    chn_start <= 6'h3f;
    @(posedge sys_clk);
    chn_start <= '0;
    clk(1);
    @(negedge sys_clk);
    `CHK("running", 6'h3f, chn_running)
    for (int k = 0; k < 6; k++) begin
      gap(k, g);
      `CHK("match gap", int'(per[k]) + 1, g)
    end
    @(posedge sys_clk);
    chn_stop <= 6'h3f;
    @(posedge sys_clk);
    chn_stop <= '0;
    clk(1);
    @(negedge sys_clk);
    `CHK("stopped", 6'h0, chn_running)
    $display("test channels done");
    // lower period 3 so the upper steps every four cycles
    @(posedge sys_clk);
    chn_period[31:0] <= 32'hffff_0003;
    chn_cascade <= 6'h02;
    chn_start <= 6'h03;
    @(posedge sys_clk);
    chn_start <= '0;
    for (i = 0; i < 100 && chn_cascade_ok[1] !== 1'h1; i++)
      @(negedge sys_clk);
    `CHK("armed", 1'h1, chn_cascade_ok[1])
    `CHK("armed upper", 16'h0, chn_count[31:16])
    clk(16);
    @(negedge sys_clk);
    `CHK("upper steps", 16'h4, chn_count[31:16])
    p = chn_count[31:0];
    @(negedge sys_clk);
    `CHK("pair", p, pair_combined)
    @(posedge sys_clk);
    pair_sel <= 3'h0;
    chn_stop <= 6'h03;
    @(posedge sys_clk);
    chn_stop <= '0;
    chn_cascade <= '0;
    @(negedge sys_clk);
    `CHK("pair invalid", 32'h0, pair_combined)
    // three-channel chain: channel 2 steps on every fourth cycle
    @(posedge sys_clk);
    chn_period[47:0] <= 48'hffff_0001_0001;
    chn_cascade <= 6'h06;
    chn_start <= 6'h07;
    @(posedge sys_clk);
    chn_start <= '0;
    for (i = 0; i < 100 && chn_cascade_ok[2] !== 1'h1; i++)
      @(negedge sys_clk);
    `CHK("chain armed", 1'h1, chn_cascade_ok[2])
    `CHK("chain upper", 16'h0, chn_count[47:32])
    clk(16);
    @(negedge sys_clk);
    `CHK("chain steps", 16'h4, chn_count[47:32])
    @(posedge sys_clk);
    chn_stop <= 6'h07;
    @(posedge sys_clk);
    chn_stop <= '0;
    chn_cascade <= '0;
    $display("test cascade done");
    @(posedge sys_clk);
    lf = lfsr(lf);
    hi = {13'h0, lf[2:0]};
    pwm_enable <= 1'h1;
    pwm_high_time <= hi;
    chn_period[15:0] <= 16'h9;
    chn_start <= 6'h01;
    @(posedge sys_clk);
    chn_start <= '0;
    clk(4);
    g = 0;
    repeat (10) begin
      @(negedge sys_clk);
      g += int'(pwm_out === 1'h1);
    end
    `CHK("pwm high", int'(hi), g)
    $display("test pwm done");
    @(posedge sys_clk);
    stb_period <= 32'h5;
    stb_start <= 1'h1;
    @(posedge sys_clk);
    stb_start <= 1'h0;
    g = wakes;
    stick(5);
    `CHK("early wake", 0, wakes - g)
    stick(1);
    `CHK("wake", 1, wakes - g)
    stick(3);
    ps_exit <= 1'h1;
    @(posedge sys_clk);
    ps_exit <= 1'h0;
    stb_stop <= 1'h1;
    @(posedge sys_clk);
    stb_stop <= 1'h0;
    clk(1);
    @(negedge sys_clk);
    `CHK("capture", 32'h3, stb_capture)
    `CHK("stb stopped", 1'h0, stb_running)
    $display("test standby done");
    @(posedge sys_clk);
    rtc_calib_value <= 16'h3;
    rtc_calib_load <= 1'h1;
    @(posedge sys_clk);
    rtc_calib_load <= 1'h0;
    rtc_enable <= 1'h1;
    @(posedge sys_clk);
    stick(8);
    `CHK("seconds", 32'h2, rtc_seconds)
    rtc_enable <= 1'h0;
    @(posedge sys_clk);
    rtc_enable <= 1'h1;
    @(negedge sys_clk);
    `CHK("cleared", 32'h0, rtc_seconds)
    @(posedge sys_clk);
    stick(4);
    `CHK("restart", 32'h1, rtc_seconds)
    $display("test rtc done");
    end_sim();
  end
endmodule
bind timer_unit timer_unit_chk u_chk (.*);
